//--- rtl/sld_map.svh
// constants for the supply low detector: offsets, fields, reset values, timing
// assumes a 10 MHz system clock and the plain register port of sld_top
// Operation
// (RULE1) three-bit threshold select picks supply level
// (RULE2) read-only flag shows low-voltage condition
// (RULE3) enable bit switches detector on/off
// (RULE4) flag high when supply below threshold
// (RULE5) detector keeps running while powered down
// (RULE6) software waits settle delay before trusting flag
// (RULE7) flag may toggle near the threshold
// (RULE8) request raised after fixed delay from flag
// (RULE9) request routed via multi-function group
// (RULE10) powered-down low supply sets flag, wakes
// (RULE11) software presets request flag to block wake
// (RULE12) software clears request flag before enabling
// (RULE13) servicing clears group flag, not request flag
// (RULE14) branch needs global, own and group enables
// (RULE15) wake on request rising edge, enables ignored
// (RULE16) comparator output passes two-stage synchroniser
`ifndef SLD_MAP_SVH
`define SLD_MAP_SVH
`define SLD_ADDR_W          4
`define SLD_OFF_CONTROL     4'h0
`define SLD_OFF_IRQ         4'h1
`define SLD_CTRL_RESET      8'h00
`define SLD_IRQ_RESET       8'h00
`define SLD_BIT_FLAG        5
`define SLD_BIT_ENABLE      4
`define SLD_SEL_HI          2
`define SLD_SEL_LO          0
`define SLD_BIT_REQ         0
`define SLD_BIT_IRQ_EN      1
`define SLD_BIT_GRP_EN      2
`define SLD_BIT_GRP_FLAG    3
`define SLD_BIT_GLOBAL_EN   4
`define SLD_CLK_HZ          10000000
`define SLD_IRQ_DELAY_US    15
`define SLD_IRQ_DELAY_CYC   ((`SLD_IRQ_DELAY_US * `SLD_CLK_HZ) / 1000000)
`define SLD_CNT_W           8
`endif

//--- rtl/sld_pkg.sv
// types for the supply low detector
package sld_pkg;
  typedef enum logic [2:0] {
    SLD_OFF     = 3'b001,
    SLD_WATCH   = 3'b010,
    SLD_DELAY   = 3'b100
  } sld_state_e;
  typedef logic [7:0] sld_byte_t;
endpackage

//--- rtl/sld_sync.sv
// two-stage level synchroniser
// assumes d_in is asynchronous to clock
`timescale 1ns/100ps
module sld_sync (
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic d_in,
  output logic      q_out
);
  logic stage1;
  always_ff @(posedge clock) begin
    if (reset) begin
      stage1 <= 1'b0;
      q_out  <= 1'b0;
    end else begin
      stage1 <= d_in; // RULE16
      q_out  <= stage1;
    end
  end
endmodule

//--- rtl/sld_top.sv
// control register, detection flag and request logic of the supply low detector
// assumes the analog comparator drives comparator_low asynchronously, high when
// the supply is below the level chosen by threshold_select
// assumes irq_service is a one-cycle pulse from the core on this clock
// assumes the core gates irq_request with its own stack and power-down state
// the register port never stalls: read data stand in the cycle after the strobe
//
// Local design decisions: the strobed register port and the placing of the registers.
`include "sld_map.svh"
`timescale 1ns/100ps
module sld_top
  import sld_pkg::*;
(
  input  wire logic                   clock,
  input  wire logic                   reset,
  input  wire logic [`SLD_ADDR_W-1:0] address,
  input  wire logic [7:0]             write_data,
  input  wire logic                   write_strobe,
  input  wire logic                   read_strobe,
  output sld_byte_t                   read_data,
  input  wire logic                   comparator_low,
  input  wire logic                   irq_service,
  output logic                        detector_on,
  output logic [2:0]                  threshold_select,
  output logic                        irq_request,
  output logic                        wake_up
);
  logic                  detector_enable;
  logic                  low_voltage_flag;
  logic                  low_voltage_request_flag;
  logic                  low_voltage_irq_enable;
  logic                  group_irq_enable;
  logic                  group_flag;
  logic                  global_irq_enable;
  logic                  comp_sync;
  logic                  flag_prev;
  logic                  req_prev;
  logic [`SLD_CNT_W-1:0] delay_count;
  sld_state_e            state;
  logic                  ctrl_wr;
  logic                  irq_wr;
  logic                  delay_done;
  // read-back words
  sld_byte_t             control_word;
  sld_byte_t             irq_word;

  function automatic logic hit(input logic [`SLD_ADDR_W-1:0] a,
                               input logic [`SLD_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  // write decodes, one per register
  assign ctrl_wr    = write_strobe && hit(address, `SLD_OFF_CONTROL);
  assign irq_wr     = write_strobe && hit(address, `SLD_OFF_IRQ);
  // last count of the delay; the request is set on the edge that ends it
  assign delay_done = (state == SLD_DELAY) &&
                      (delay_count == `SLD_CNT_W'(`SLD_IRQ_DELAY_CYC - 1));
  // register views, assembled once for the read port
  assign control_word = {2'b00, low_voltage_flag, detector_enable, 1'b0, threshold_select};
  assign irq_word     = {3'b000, global_irq_enable, group_flag, group_irq_enable,
                         low_voltage_irq_enable, low_voltage_request_flag};

  // comparator crosses into this clock through two flops before any use
  sld_sync u_sync (
    .clock (clock),
    .reset (reset),
    .d_in  (comparator_low),
    .q_out (comp_sync)
  );

  // detector enable bit
  always_ff @(posedge clock) begin
    if (reset) begin
      detector_enable <= 1'b0;
    end else if (ctrl_wr) begin
      detector_enable <= write_data[`SLD_BIT_ENABLE]; // RULE3
    end
  end

  // threshold select field, passed straight to the analog reference
  always_ff @(posedge clock) begin
    if (reset) begin
      threshold_select <= 3'h0;
    end else if (ctrl_wr) begin
      threshold_select <= write_data[`SLD_SEL_HI:`SLD_SEL_LO]; // RULE1
    end
  end

  // detector power drives straight from the enable, independent of power-down
  always_ff @(posedge clock) begin
    if (reset) detector_on <= 1'b0;
    else detector_on <= detector_enable; // RULE5
  end

  // flag follows the synchronised comparator every cycle while detector_enable is set, glitches included
  always_ff @(posedge clock) begin
    if (reset) low_voltage_flag <= 1'b0;
    else low_voltage_flag <= detector_enable & comp_sync; // RULE2 RULE4 RULE7
  end

  // previous flag level, for the rising-edge test of the sequencer
  always_ff @(posedge clock) begin
    if (reset) flag_prev <= 1'b0;
    else flag_prev <= low_voltage_flag;
  end

  // request delay sequencer; edges seen while the delay runs are not queued,
  // only a flag still high when the delay ends sets the request
  always_ff @(posedge clock) begin
    if (reset) begin
      state <= SLD_OFF;
    end else begin
      case (state)
        SLD_OFF: begin
          if (detector_enable) state <= SLD_WATCH;
        end
        SLD_WATCH: begin
          if (!detector_enable) state <= SLD_OFF;
          else if (low_voltage_flag && !flag_prev) state <= SLD_DELAY; // RULE8
        end
        SLD_DELAY: begin
          if (!detector_enable || delay_done) state <= SLD_WATCH; // RULE8
        end
        default: state <= SLD_OFF;
      endcase
    end
  end

  // delay counter runs only in the delay state and restarts from zero each time
  always_ff @(posedge clock) begin
    if (reset || state != SLD_DELAY) delay_count <= '0;
    else delay_count <= delay_count + `SLD_CNT_W'(1);
  end

  // request flag; the hardware set wins over a write, service leaves it alone
  always_ff @(posedge clock) begin
    if (reset) begin
      low_voltage_request_flag <= 1'b0;
    end else if (delay_done && low_voltage_flag) begin
      low_voltage_request_flag <= 1'b1; // RULE10 RULE13
    end else if (irq_wr) begin
      low_voltage_request_flag <= write_data[`SLD_BIT_REQ];
    end
  end

  // own interrupt enable
  always_ff @(posedge clock) begin
    if (reset) begin
      low_voltage_irq_enable <= 1'b0;
    end else if (irq_wr) begin
      low_voltage_irq_enable <= write_data[`SLD_BIT_IRQ_EN];
    end
  end

  // group interrupt enable
  always_ff @(posedge clock) begin
    if (reset) begin
      group_irq_enable <= 1'b0;
    end else if (irq_wr) begin
      group_irq_enable <= write_data[`SLD_BIT_GRP_EN];
    end
  end

  // group flag: set by the request, cleared by service, the set beats the clear
  always_ff @(posedge clock) begin
    if (reset) begin
      group_flag <= 1'b0;
    end else if (delay_done && low_voltage_flag) begin
      group_flag <= 1'b1; // RULE9
    end else if (irq_service) begin
      group_flag <= 1'b0; // RULE13
    end else if (irq_wr) begin
      group_flag <= write_data[`SLD_BIT_GRP_FLAG];
    end
  end

  // global enable, dropped by service so that no other branch nests
  always_ff @(posedge clock) begin
    if (reset) begin
      global_irq_enable <= 1'b0;
    end else if (irq_service) begin
      global_irq_enable <= 1'b0; // RULE13
    end else if (irq_wr) begin
      global_irq_enable <= write_data[`SLD_BIT_GLOBAL_EN];
    end
  end

  // previous request level for the wake edge
  always_ff @(posedge clock) begin
    if (reset) req_prev <= 1'b0;
    else req_prev <= low_voltage_request_flag;
  end

  // branch request needs all three enables; a service cycle drops it at once
  always_ff @(posedge clock) begin
    if (reset) begin
      irq_request <= 1'b0;
    end else begin
      irq_request <= global_irq_enable & group_irq_enable & low_voltage_irq_enable &
                     low_voltage_request_flag & !irq_service; // RULE14 RULE9
    end
  end

  // wake pulse on each rising edge of the request flag, enables ignored
  always_ff @(posedge clock) begin
    if (reset) begin
      wake_up <= 1'b0;
    end else begin
      wake_up <= low_voltage_request_flag & !req_prev; // RULE15 RULE10
    end
  end

  // read port, answer one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clock) begin
    if (reset) begin
      read_data <= 8'h00;
    end else if (read_strobe && hit(address, `SLD_OFF_CONTROL)) begin
      read_data <= control_word; // RULE2
    end else if (read_strobe && hit(address, `SLD_OFF_IRQ)) begin
      read_data <= irq_word;
    end else begin
      read_data <= 8'h00;
    end
  end
endmodule

//--- bench/sld_checker.sv
// assertions on the ports of sld_top
// assumes a bind into sld_top, one clock domain
`timescale 1ns/100ps
module sld_checker
  import sld_pkg::*;
(
  input wire logic       clock,
  input wire logic       reset,
  input wire logic [3:0] address,
  input wire logic [7:0] write_data,
  input wire logic       write_strobe,
  input wire logic       read_strobe,
  input wire sld_byte_t  read_data,
  input wire logic       comparator_low,
  input wire logic       irq_service,
  input wire logic       detector_on,
  input wire logic [2:0] threshold_select,
  input wire logic       irq_request,
  input wire logic       wake_up
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  property p_rd_gap; !$past(read_strobe) |-> read_data == 8'h00; endproperty
  a_rd_gap: assert property (p_rd_gap) else $error("read data out of slot");
  property p_unmap; $past(read_strobe && address > 4'h1) |-> read_data == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_ctl_zero; $past(read_strobe && address == 4'h0) |-> read_data[7:6] == 2'h0
    && !read_data[3]; endproperty
  a_ctl_zero: assert property (p_ctl_zero) else $error("unused bits set");
  property p_enable; write_strobe && address == 4'h0 |-> ##2
    detector_on == $past(write_data[4], 2); endproperty
  a_enable: assert property (p_enable) else $error("enable not applied");
  property p_select; write_strobe && address == 4'h0 |=>
    threshold_select == $past(write_data[2:0]); endproperty
  a_select: assert property (p_select) else $error("select not applied");
  property p_wake_pulse; wake_up |=> !wake_up; endproperty
  a_wake_pulse: assert property (p_wake_pulse) else $error("wake too long");
  property p_service; irq_service |-> ##[1:2] !irq_request; endproperty
  a_service: assert property (p_service) else $error("request kept");
  property p_delay; $rose(comparator_low) && detector_on |-> !wake_up [*8]; endproperty
  a_delay: assert property (p_delay) else $error("request too early");
  c_wake: cover property (wake_up);
  c_irq: cover property (irq_request);
  c_serv: cover property (irq_service && irq_request);
endmodule
bind sld_top sld_checker sld_checker_inst (.clock, .reset, .address, .write_data,
  .write_strobe, .read_strobe, .read_data, .comparator_low, .irq_service,
  .detector_on, .threshold_select, .irq_request, .wake_up);

//--- bench/tb_top.sv
// register-level bench for sld_top
// assumes sld_pkg, sld_top and sld_checker compiled first
`timescale 1ns/100ps
`include "sld_map.svh"
module tb_top
  import sld_pkg::*;
;
  logic       clock, reset, write_strobe, read_strobe, comparator_low, irq_service;
  logic [3:0] address;
  logic [7:0] write_data;
  logic [7:0] wakes = 8'h00;
  sld_byte_t  read_data;
  logic       detector_on, irq_request, wake_up;
  logic [2:0] threshold_select;
  int         errors = 0, checks_done = 0, n;
  // settle wait after enabling the detector; the wake search limit
  localparam int settle_cycles = 20;
  localparam int wait_max      = `SLD_IRQ_DELAY_CYC + 40;
  sld_top sld_top_inst (.clock, .reset, .address, .write_data, .write_strobe,
    .read_strobe, .read_data, .comparator_low, .irq_service, .detector_on,
    .threshold_select, .irq_request, .wake_up);
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock) if (wake_up === 1'b1) wakes <= wakes + 8'h01;
  task automatic conclude();
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(string what, sld_byte_t seen, sld_byte_t exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge clock);
    address <= a;
    write_data <= d;
    write_strobe <= 1'b1;
    @(posedge clock);
    write_strobe <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, sld_byte_t exp);
    @(posedge clock);
    address <= a;
    read_strobe <= 1'b1;
    @(posedge clock);
    read_strobe <= 1'b0;
    #1 chk("read", read_data, exp);
  endtask
  // drop the comparator, raise it again, count cycles to the next wake
  task automatic pulse_comp();
    logic [7:0] w;
    @(posedge clock);
    comparator_low <= 1'b0;
    repeat (5) @(posedge clock);
    comparator_low <= 1'b1;
    w = wakes;
    n = 0;
    while (wakes === w && n < wait_max) begin
      @(posedge clock);
      n++;
    end
  endtask
  initial begin
    {address, write_data, write_strobe, read_strobe, comparator_low, irq_service} = '0;
    reset = 1'b1;
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    rd(4'h0, 8'h00);
    rd(4'h1, 8'h00);
    wr(4'h5, 8'hff);
    rd(4'h5, 8'h00);
    rd(4'h0, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr(4'h0, 8'h10 | 8'(i));
      rd(4'h0, 8'h10 | 8'(i));
      chk("select", 8'(threshold_select), 8'(i));
    end
    wr(4'h0, 8'hff);
    repeat (settle_cycles) @(posedge clock);
    rd(4'h0, 8'h17);
    pulse_comp();
    // two sync flops, flag, edge, delay, request, wake, count: delay plus seven
    chk("delay", 8'(n), 8'(`SLD_IRQ_DELAY_CYC + 7));
    rd(4'h0, 8'h37);
    rd(4'h1, 8'h09);
    chk("irq", 8'(irq_request), 8'h00);
    wr(4'h1, 8'h1e);
    rd(4'h1, 8'h1e);
    pulse_comp();
    @(posedge clock);
    #1 chk("irq", 8'(irq_request), 8'h01);
    @(posedge clock);
    irq_service <= 1'b1;
    @(posedge clock);
    irq_service <= 1'b0;
    repeat (2) @(posedge clock);
    #1 chk("irq", 8'(irq_request), 8'h00);
    rd(4'h1, 8'h07);
    wr(4'h1, 8'h07);
    pulse_comp();
    chk("nowake", 8'(n), 8'(wait_max));
    wr(4'h0, 8'h07);
    rd(4'h0, 8'h07);
    chk("on", 8'(detector_on), 8'h00);
    conclude();
  end
  initial begin
    repeat (3000) @(posedge clock);
    errors++;
    conclude();
  end
endmodule
